// ===== logic/efs_voice_adapt.sv
`timescale 1ns/1ps
module efs_voice_adapt import efs_pkg::*; #(
	parameter int unsigned CYC_MS = CYC_PER_MS,
	parameter int unsigned COEF_W = 12,
	parameter int unsigned CNT_W = 10
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic longMode,
	input wire logic sampleValid,
	input wire logic [7:0] sampleAmp,
	input wire logic auxValid,
	input wire logic auxLast,
	input wire logic [COEF_W-1:0] auxMag,
	output logic silenceActive,
	output logic turboActive,
	output logic newPathAdapting,
	output logic slowdownActive,
	output logic limitUpdateOne
);
	localparam int unsigned TW = $clog2(CYC_MS);

	logic [7:0] intervalsQ, hangoverQ, countInitQ, turboQ, supervQ;
	logic [6:0] configQ;
	logic ackQ;
	logic [9:0] regIdx;
	logic req;
	logic [TW-1:0] tickCntQ;
	logic msTick;
	logic [7:0] peakMsQ, winMsQ, hangMsQ;
	logic [7:0] peakLen, winLen, hangLen;
	logic peakEnd, winEnd;
	logic [7:0] peakRunQ, peakQ;
	logic [7:0] diffUnits, peakGap;
	logic qualify;
	logic [10:0] silCntQ, initVal;
	logic winSilentQ, silenceQ;
	logic [11:0] fast_adapt_threshold, largeTh, thrOff;
	logic curBig, curLarge, bigSeenQ, slowNow, turboRegQ, slowRegQ;
	logic [CNT_W-1:0] largeCntQ, largeTot;
	logic [CNT_W+2:0] largeNeed;
	logic hyst;

	function automatic logic [7:0] winMs(input logic [3:0] code);
		winMs = 8'(({4'h0, code} + 8'h01) * MS_PER_STEP);
	endfunction

	// Bus decode
	assign regIdx = address[11:2];
	assign req = read | write;
	assign waitrequest = req & ~ackQ;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ackQ <= 1'b0;
		end else if (ce) begin
			ackQ <= req & ~ackQ;
		end
	end

	// Writable registers, low byte lane only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intervalsQ <= RST_INTERVALS;
			hangoverQ <= RST_HANGOVER;
			countInitQ <= RST_COUNT_INIT;
			turboQ <= RST_TURBO;
			supervQ <= RST_SUPERV;
			configQ <= RST_CONFIG;
		end else if (ce && write && !ackQ && byteenable[0]) begin
			unique case (regIdx)
				IDX_INTERVALS: intervalsQ <= writedata[7:0];
				IDX_HANGOVER: hangoverQ <= writedata[7:0];
				IDX_COUNT_INIT: countInitQ <= writedata[7:0];
				IDX_TURBO: turboQ <= {4'h0, writedata[3:0]};
				IDX_SUPERV: supervQ <= writedata[7:0];
				IDX_CONFIG: configQ <= writedata[6:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readdata <= 32'h0000_0000;
		end else if (ce && read && !ackQ) begin
			unique case (regIdx)
				IDX_INTERVALS: readdata <= {24'h00_0000, intervalsQ};
				IDX_HANGOVER: readdata <= {24'h00_0000, hangoverQ};
				IDX_COUNT_INIT: readdata <= {24'h00_0000, countInitQ};
				IDX_TURBO: readdata <= {24'h00_0000, turboQ};
				IDX_SUPERV: readdata <= {24'h00_0000, supervQ};
				IDX_CONFIG: readdata <= {25'h000_0000, configQ};
				IDX_STATUS: readdata <= {28'h000_0000, limitUpdateOne, slowRegQ,
					turboRegQ, silenceQ};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Millisecond tick
	assign msTick = (tickCntQ == TW'(CYC_MS - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCntQ <= '0;
		end else if (ce) begin
			tickCntQ <= msTick ? '0 : tickCntQ + TW'(1);
		end
	end

	assign peakLen = winMs(intervalsQ[7:4]);
	assign winLen = winMs(intervalsQ[3:0]);
	assign hangLen = winMs(hangoverQ[7:4]);
	assign peakEnd = msTick && (peakMsQ == peakLen - 8'h01);
	assign winEnd = msTick && (winMsQ == winLen - 8'h01);
	assign hyst = configQ[CFG_HYST_BIT];

	// Peak search window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			peakMsQ <= 8'h00;
			peakRunQ <= 8'h00;
			peakQ <= 8'h00;
		end else if (ce) begin
			if (msTick) begin
				peakMsQ <= peakEnd ? 8'h00 : peakMsQ + 8'h01;
			end
			if (peakEnd) begin
				peakQ <= (sampleValid && sampleAmp > peakRunQ) ? sampleAmp : peakRunQ;
				peakRunQ <= 8'h00;
			end else if (sampleValid && sampleAmp > peakRunQ) begin
				peakRunQ <= sampleAmp;
			end
		end
	end

	// Sample criterion
	assign diffUnits = 8'(hangoverQ[3:0] * UNITS_PER_3DB);
	assign peakGap = (peakQ > sampleAmp) ? peakQ - sampleAmp : 8'h00;
	assign qualify = sampleValid && (peakGap < diffUnits)
		&& !(configQ[CFG_IGNORE_BIT] && sampleAmp > LOUD_LIMIT);
	assign initVal = longMode ? {2'b00, countInitQ, 1'b0} : {3'b000, countInitQ};

	// Silence counting window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			winMsQ <= 8'h00;
			silCntQ <= 11'h000;
			winSilentQ <= 1'b0;
		end else if (ce) begin
			if (msTick) begin
				winMsQ <= winEnd ? 8'h00 : winMsQ + 8'h01;
			end
			if (winEnd) begin
				silCntQ <= initVal;
				winSilentQ <= silCntQ >= (longMode ? SILENT_128 : SILENT_64);
			end else if (qualify && silCntQ != 11'h7FF) begin
				silCntQ <= silCntQ + 11'h001;
			end
		end
	end

	// Silence output and hang-over
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hangMsQ <= 8'h00;
			silenceQ <= 1'b0;
		end else if (ce) begin
			if (!hyst) begin
				silenceQ <= winSilentQ;
				hangMsQ <= 8'h00;
			end else if (winSilentQ) begin
				silenceQ <= 1'b1;
				hangMsQ <= 8'h00;
			end else if (silenceQ && msTick) begin
				if (hangMsQ == hangLen - 8'h01) begin
					silenceQ <= 1'b0;
					hangMsQ <= 8'h00;
				end else begin
					hangMsQ <= hangMsQ + 8'h01;
				end
			end
		end
	end
	assign silenceActive = silenceQ;

	// Coefficient supervision
	assign fast_adapt_threshold = TURBO_BASE + {6'h00, turboQ[3:0], 2'b00};
	always_comb begin
		unique case (supervQ[1:0])
			2'b00: thrOff = MARGIN_32;
			2'b01: thrOff = MARGIN_16;
			default: thrOff = MARGIN_8;
		endcase
	end
	assign largeTh = fast_adapt_threshold - thrOff;
	assign curBig = auxValid && (12'(auxMag) > fast_adapt_threshold);
	assign curLarge = auxValid && (12'(auxMag) > largeTh);
	assign largeTot = largeCntQ + CNT_W'(curLarge);
	assign largeNeed = {{(CNT_W-5){1'b0}}, supervQ[6:2], 3'b000};
	assign slowNow = (supervQ[6:2] != 5'h00)
		&& ({3'b000, largeTot} >= largeNeed);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			largeCntQ <= '0;
			bigSeenQ <= 1'b0;
			turboRegQ <= 1'b0;
			slowRegQ <= 1'b0;
		end else if (ce && auxValid) begin
			if (auxLast) begin
				slowRegQ <= slowNow;
				turboRegQ <= (bigSeenQ || curBig) && !slowNow;
				largeCntQ <= '0;
				bigSeenQ <= 1'b0;
			end else begin
				if (largeCntQ != '1) begin
					largeCntQ <= largeTot;
				end
				bigSeenQ <= bigSeenQ || curBig;
			end
		end
	end
	assign turboActive = turboRegQ;
	assign newPathAdapting = turboRegQ;
	assign slowdownActive = slowRegQ;
	assign limitUpdateOne = slowRegQ && supervQ[SUP_EFFECT_BIT];

	// Checks
	sequence reqOpen;
		ce && req && !ackQ;
	endsequence

	sequence setEnd;
		ce && auxValid && auxLast;
	endsequence

	busAnswer_a: assert property (@(posedge clk) disable iff (!arst_n)
		reqOpen ##1 ce |-> !waitrequest)
		else $error("bus answer missing");

	turboSet_a: assert property (@(posedge clk) disable iff (!arst_n)
		setEnd and (curBig && !slowNow) |=> turboActive)
		else $error("turbo not raised");

	turboSlow_a: assert property (@(posedge clk) disable iff (!arst_n)
		slowdownActive |-> !turboActive && limitUpdateOne == supervQ[SUP_EFFECT_BIT])
		else $error("slow-down effect wrong");

	slowOff_a: assert property (@(posedge clk) disable iff (!arst_n)
		setEnd and (supervQ[6:2] == 5'h00) |=> !slowdownActive)
		else $error("supervision not disabled");

	windowReload_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && winEnd |=> silCntQ == $past(initVal))
		else $error("counter not reloaded");

	windowJudge_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && winEnd && !longMode |=> winSilentQ == ($past(silCntQ) >= 11'h200))
		else $error("silence decision wrong");

	loudIgnore_a: assert property (@(posedge clk) disable iff (!arst_n)
		configQ[CFG_IGNORE_BIT] && sampleAmp > 8'h7E |-> !qualify)
		else $error("loud sample counted");

	marginCheck_a: assert property (@(posedge clk) disable iff (!arst_n)
		qualify |-> (peakQ <= sampleAmp) || (peakQ - sampleAmp < diffUnits))
		else $error("sample outside margin counted");

	noHyst_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !hyst ##1 ce && !hyst |-> silenceActive == $past(winSilentQ))
		else $error("silence not following window");

	hangHold_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && hyst && silenceQ && !msTick && !winSilentQ |=> silenceActive)
		else $error("hang-over dropped early");

	hangEnd_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && hyst && silenceQ && !winSilentQ && msTick && hangMsQ == hangLen - 8'h01
		|=> !silenceActive)
		else $error("hang-over not ended");

	hystSet_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && hyst && winSilentQ |=> silenceActive)
		else $error("silence not raised with hysteresis");

	peakClear_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && peakEnd |=> peakRunQ == 8'h00)
		else $error("peak run not restarted");

	peakTrack_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !peakEnd && sampleValid && sampleAmp > peakRunQ |=> peakRunQ == $past(sampleAmp))
		else $error("peak not tracked");

	winCount_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !winEnd && qualify && silCntQ != 11'h7FF |=> silCntQ == $past(silCntQ) + 11'h001)
		else $error("qualifying sample not counted");

	initShort_a: assert property (@(posedge clk) disable iff (!arst_n)
		!longMode |-> initVal == {3'b000, countInitQ})
		else $error("short init wrong");

	initLong_a: assert property (@(posedge clk) disable iff (!arst_n)
		longMode |-> initVal == {2'b00, countInitQ, 1'b0})
		else $error("long init wrong");

	judgeLong_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && winEnd && longMode |=> winSilentQ == ($past(silCntQ) >= 11'h400))
		else $error("long silence decision wrong");

	marginMap_a: assert property (@(posedge clk) disable iff (!arst_n)
		diffUnits == {3'b000, hangoverQ[3:0], 1'b0})
		else $error("margin mapping wrong");

	turboField_a: assert property (@(posedge clk) disable iff (!arst_n)
		turboQ[7:4] == 4'h0)
		else $error("turbo field too wide");

	turboClear_a: assert property (@(posedge clk) disable iff (!arst_n)
		setEnd and (!bigSeenQ && !curBig) |=> !turboActive)
		else $error("turbo not cleared");

	newPath_a: assert property (@(posedge clk) disable iff (!arst_n)
		newPathAdapting == turboActive)
		else $error("new path flag differs");

	largeWide_a: assert property (@(posedge clk) disable iff (!arst_n)
		supervQ[1:0] == 2'b00 |-> largeTh == fast_adapt_threshold - 12'h020)
		else $error("large margin 32 wrong");

	largeNarrow_a: assert property (@(posedge clk) disable iff (!arst_n)
		supervQ[1:0] == 2'b11 |-> largeTh == fast_adapt_threshold - 12'h008)
		else $error("large margin 8 wrong");

	slowOn_a: assert property (@(posedge clk) disable iff (!arst_n)
		setEnd and (supervQ[6:2] != 5'h00 && {3'b000, largeTot} >= largeNeed) |=> slowdownActive)
		else $error("slow-down not raised");

	limitOff_a: assert property (@(posedge clk) disable iff (!arst_n)
		!supervQ[SUP_EFFECT_BIT] |-> !limitUpdateOne)
		else $error("update limit without effect bit");

	ceFreeze_a: assert property (@(posedge clk) disable iff (!arst_n)
		!ce |=> $stable(tickCntQ) && $stable(silCntQ))
		else $error("state moved while frozen");
endmodule

// ===== shared/efs_pkg.sv
// Behaviour
// - Peak-search window code n tracks the peak for 8*(n+1) ms, 8 to 128 ms.
// - Silence check window code n spans 8*(n+1) ms, like the echo path delay field.
// - Hang-over code n keeps silence for 8*(n+1) ms after its last detection.
// - Hang-over only applies while silence hysteresis is enabled.
// - A sample counts only if it lies less than the margin below the peak.
// - Peak difference margin code maps 0 to 45 dB in 3 dB steps, reset 12 dB.
// - Qualifying samples are counted from a value derived from the 8-bit init.
// - Silence when the window count ends at or above 512 (64 ms) or 1024 (128 ms).
// - Turbo when any aux magnitude exceeds 351 plus four times the threshold field.
// - Turbo indicates adaptation to a new end echo path.
// - Slow-down disables turbo; effect bit one also limits updates to plus/minus one.
// - Slow-down when large aux count reaches 8 times the limit; zero disables.
// - Large means above turbo threshold minus 32, 16, 8 or 8 by margin code.
// - No hysteresis: silence follows the current window; with it, held for hang-over.
// - Ignore-loud option drops samples with log amplitude above 126.
package efs_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned TICK_TIME_US = 1000;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * TICK_TIME_US;
	localparam logic [7:0] MS_PER_STEP = 8'h08;
	localparam logic [9:0] IDX_INTERVALS = 10'h073;
	localparam logic [9:0] IDX_HANGOVER = 10'h074;
	localparam logic [9:0] IDX_COUNT_INIT = 10'h075;
	localparam logic [9:0] IDX_TURBO = 10'h077;
	localparam logic [9:0] IDX_SUPERV = 10'h078;
	localparam logic [9:0] IDX_CONFIG = 10'h079;
	localparam logic [9:0] IDX_STATUS = 10'h07C;
	localparam logic [7:0] RST_INTERVALS = 8'h77;
	localparam logic [7:0] RST_HANGOVER = 8'h74;
	localparam logic [7:0] RST_COUNT_INIT = 8'h85;
	localparam logic [7:0] RST_TURBO = 8'h08;
	localparam logic [7:0] RST_SUPERV = 8'h00;
	localparam logic [6:0] RST_CONFIG = 7'h10;
	localparam int unsigned CFG_HYST_BIT = 5;
	localparam int unsigned CFG_IGNORE_BIT = 4;
	localparam int unsigned SUP_EFFECT_BIT = 7;
	localparam logic [11:0] TURBO_BASE = 12'h15F;
	localparam logic [11:0] MARGIN_32 = 12'h020;
	localparam logic [11:0] MARGIN_16 = 12'h010;
	localparam logic [11:0] MARGIN_8 = 12'h008;
	localparam logic [7:0] LOUD_LIMIT = 8'h7E;
	localparam logic [7:0] UNITS_PER_3DB = 8'h02;
	localparam logic [10:0] SILENT_64 = 11'h200;
	localparam logic [10:0] SILENT_128 = 11'h400;
endpackage

// ===== test/efs_voice_adapt_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
	$display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module efs_voice_adapt_tb import efs_pkg::*; ;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0, longMode = 1'b0;
	logic sampleValid = 1'b0, auxValid = 1'b0, auxLast = 1'b0;
	logic [11:0] address = 12'h000, auxMag = 12'h000;
	logic [31:0] writedata = 32'h0000_0000, readdata, q;
	logic [3:0] byteenable = 4'h1;
	logic [7:0] sampleAmp = 8'h00;
	logic waitrequest, silenceActive, turboActive, newPathAdapting, slowdownActive, limitUpdateOne;
	int bad_count = 0, n_tests = 0;
	logic [9:0] ri [6] = '{IDX_INTERVALS, IDX_HANGOVER, IDX_COUNT_INIT, IDX_TURBO, IDX_SUPERV,
		IDX_CONFIG};
	logic [7:0] rv [6] = '{8'h77, 8'h74, 8'h85, 8'h08, 8'h00, 8'h10};
	logic [11:0] mg [4] = '{12'h020, 12'h010, 12'h008, 12'h008};

	always #5 clk = ~clk;

	efs_voice_adapt #(.CYC_MS(4)) dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .longMode(longMode),
		.sampleValid(sampleValid), .sampleAmp(sampleAmp), .auxValid(auxValid),
		.auxLast(auxLast), .auxMag(auxMag), .silenceActive(silenceActive),
		.turboActive(turboActive), .newPathAdapting(newPathAdapting),
		.slowdownActive(slowdownActive), .limitUpdateOne(limitUpdateOne));

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= {idx, 2'b00};
		writedata <= {24'h00_0000, d};
		@(posedge clk);
		while (waitrequest !== 1'b0 && t < 50) begin
			@(posedge clk);
			t++;
		end
		if (t == 50) begin
			bad_count++;
			$display("[FAIL] waitrequest exp 0 got stuck");
			summarize;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rdChk(input logic [9:0] idx, input logic [7:0] ex);
		bus(1'b0, idx, 8'h00);
		`CHK("register", {24'h00_0000, ex}, q)
	endtask

	// One coefficient set of n equal magnitudes
	task automatic aux(input int n, input logic [11:0] m);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			auxValid <= 1'b1;
			auxMag <= m;
			auxLast <= (i == n - 1);
		end
		@(posedge clk);
		auxValid <= 1'b0;
		auxLast <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic feed(input logic [7:0] a, input int n);
		@(posedge clk);
		sampleValid <= (a != 8'h00);
		sampleAmp <= a;
		repeat (n) @(posedge clk);
		sampleValid <= 1'b0;
	endtask

	task automatic st(input logic [3:0] ex);
		@(negedge clk);
		`CHK("status", ex, {limitUpdateOne, slowdownActive, turboActive, silenceActive})
		`CHK("newpath", ex[1], newPathAdapting)
	endtask

	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		foreach (ri[i]) rdChk(ri[i], rv[i]);
		rdChk(10'h076, 8'h00);
		bus(1'b1, IDX_TURBO, 8'hFF);
		rdChk(IDX_TURBO, 8'h0F);
		byteenable <= 4'h0;
		bus(1'b1, IDX_TURBO, 8'h03);
		byteenable <= 4'h1;
		rdChk(IDX_TURBO, 8'h0F);
		aux(1, 12'd411);
		st(4'b0000);
		aux(1, 12'd412);
		st(4'b0010);
		bus(1'b1, IDX_TURBO, 8'h08);
		aux(1, 12'd383);
		st(4'b0000);
		aux(1, 12'd384);
		st(4'b0010);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, IDX_SUPERV, {1'b0, 5'd1, c[1:0]});
			aux(8, 12'd384 - mg[c]);
			st(4'b0100);
			aux(8, 12'd383 - mg[c]);
			st(4'b0000);
		end
		bus(1'b1, IDX_SUPERV, 8'h04);
		aux(8, 12'd400);
		st(4'b0100);
		bus(1'b1, IDX_SUPERV, 8'h84);
		aux(8, 12'd400);
		st(4'b1100);
		aux(7, 12'd400);
		st(4'b0010);
		bus(1'b1, IDX_SUPERV, 8'h80);
		aux(8, 12'd400);
		st(4'b0010);
		aux(1, 12'd0);
		bus(1'b1, IDX_INTERVALS, 8'h7F);
		bus(1'b1, IDX_COUNT_INIT, 8'hFF);
		feed(8'd127, 1600);
		st(4'b0000);
		feed(8'd100, 2100);
		st(4'b0001);
		rdChk(IDX_STATUS, 8'h01);
		feed(8'd0, 1200);
		st(4'b0000);
		longMode <= 1'b1;
		feed(8'd100, 2100);
		st(4'b0000);
		longMode <= 1'b0;
		bus(1'b1, IDX_CONFIG, 8'h30);
		bus(1'b1, IDX_HANGOVER, 8'hF4);
		sampleAmp <= 8'd100;
		sampleValid <= 1'b1;
		for (int k = 0; k < 3000 && silenceActive !== 1'b1; k++) @(posedge clk);
		sampleValid <= 1'b0;
		repeat (700) @(posedge clk);
		st(4'b0001);
		repeat (400) @(posedge clk);
		st(4'b0000);
		summarize;
	end

	initial begin
		#300000;
		bad_count++;
		summarize;
	end
endmodule
